/* usart_baud_ctrl.sv */
/*
 Holding FIFO for transmit words and the baud generator with
 receiver/transmitter enable control.
 Assumes all inputs synchronous to mclk; the receiver framing
 logic reports its own busy level on rx_char_busy.
*/
`timescale 1ns/1ps

module hold_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        if (flush) begin
            wr_d = '0;
            rd_d = '0;
            cnt_d = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule // hold_fifo

module usart_baud_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Configuration and commands
    input wire usart_baud_pkg::baud_cfg_s cfg,
    input wire usart_baud_pkg::ctrl_cmd_s cmd,
    input wire logic ratio_wr,
    input wire logic [10:0] ratio_wdata,
    // Receiver framing status
    input wire logic rx_char_busy,
    // Transmit words
    input wire logic tx_valid,
    output logic tx_ready_in,
    input wire logic [8:0] tx_data,
    output logic tx_start,
    output logic [8:0] tx_word,
    // Serial clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    // Clock enables and status
    output logic sample_tick,
    output logic bit_tick,
    output logic etu_tick,
    output logic [10:0] card_ratio,
    output usart_baud_pkg::ctrl_status_s status
);
    logic [2:0] pre_q, pre_d;
    logic sck_prev_q, src_tick, ext_sel;
    logic [15:0] div_q, div_d, period;
    logic [2:0] acc_q, acc_d;
    logic ext_q, ext_d, div_tick, frac_on;
    logic [3:0] ovs_q, ovs_d;
    logic [10:0] etu_q, etu_d, ratio_q, ratio_d;
    logic sck_q, sck_d;
    logic rx_en_q, rx_en_d, rx_off_q, rx_off_d;
    logic tx_en_q, tx_en_d, tx_off_q, tx_off_d;
    logic tx_busy_q, tx_busy_d, start_q, start_d;
    logic [3:0] tx_bits_q, tx_bits_d;
    logic [8:0] word_q, word_d;
    logic f_valid, f_pop, flush;
    logic tx_ready_in_raw, sck_late_q, odd_trim;
    logic [8:0] f_data;

    function automatic logic [16:0] add_eighth(
        input logic [2:0] acc, input logic [2:0] fp);
        logic [3:0] s;
        s = {1'b0, acc} + {1'b0, fp};
        return {13'h0, s};
    endfunction

    // Source selection and prescaler
    assign ext_sel = (cfg.clock_source_select == usart_baud_pkg::SRC_EXT);
    always_comb begin
        pre_d = pre_q + 3'h1;
        unique case (cfg.clock_source_select)
            usart_baud_pkg::SRC_MCK: src_tick = 1'b1;
            usart_baud_pkg::SRC_DIV: src_tick = (pre_q == usart_baud_pkg::PRESC_LAST);
            usart_baud_pkg::SRC_EXT: src_tick = sck_in && !sck_prev_q;
            default: src_tick = 1'b0;
        endcase
    end

    // Integer divider with eighth-step extension
    assign frac_on = (cfg.mode == usart_baud_pkg::OP_ASYNC) && cfg.normal
                     && (cfg.fractional_eighths != 3'h0);
    always_comb begin
        logic [16:0] s;
        s = add_eighth(acc_q, cfg.fractional_eighths);
        div_d = div_q;
        acc_d = acc_q;
        ext_d = ext_q;
        div_tick = 1'b0;
        period = cfg.clock_divisor - 16'h1;
        if (cfg.clock_divisor == 16'h0) begin
            div_d = '0;
        end else if (cfg.clock_divisor == 16'h1 && !frac_on) begin
            div_tick = src_tick;
        end else if (src_tick) begin
            if (div_q >= period + 16'(ext_q)) begin
                div_tick = 1'b1;
                div_d = '0;
                acc_d = frac_on ? s[2:0] : 3'h0;
                ext_d = frac_on && s[3];
            end else begin
                div_d = div_q + 16'h1;
            end
        end
    end

    // Oversampling stage and bit clock choice
    always_comb begin
        ovs_d = ovs_q;
        sample_tick = 1'b0;
        bit_tick = 1'b0;
        if (cfg.mode == usart_baud_pkg::OP_ASYNC) begin
            sample_tick = div_tick;
            if (div_tick) begin
                if (ovs_q >= (cfg.over8 ? usart_baud_pkg::OVS8_LAST
                                        : usart_baud_pkg::OVS16_LAST)) begin
                    ovs_d = '0;
                    bit_tick = 1'b1;
                end else begin
                    ovs_d = ovs_q + 4'h1;
                end
            end
        end else if (cfg.mode == usart_baud_pkg::OP_CARD) begin
            sample_tick = div_tick;
            bit_tick = etu_tick;
        end else if (ext_sel) begin
            bit_tick = src_tick;
        end else begin
            bit_tick = div_tick;
        end
    end

    // Card sampling divider and ratio register
    always_comb begin
        ratio_d = ratio_wr ? ratio_wdata : ratio_q;
        etu_d = etu_q;
        etu_tick = 1'b0;
        if (cfg.mode == usart_baud_pkg::OP_CARD && div_tick && ratio_q != 11'h0) begin
            if (etu_q >= ratio_q - 11'h1) begin
                etu_d = '0;
                etu_tick = 1'b1;
            end else begin
                etu_d = etu_q + 11'h1;
            end
        end
    end

    // Serial clock pin: toggle at period end and at half period
    always_comb begin
        sck_d = sck_q;
        if (cfg.clock_divisor == 16'h0 || ext_sel) begin
            sck_d = 1'b0;
        end else if (src_tick && (div_q == (period >> 1) || div_tick)) begin
            sck_d = !sck_q;
        end
    end
    assign sck_oe = cfg.serial_clock_drive_out && !ext_sel
                    && cfg.mode != usart_baud_pkg::OP_ASYNC;
    // Odd divisor on the master clock: a falling-edge copy
    // stretches the short high phase by half a cycle
    always_ff @(negedge mclk) begin
        sck_late_q <= sck_q;
    end
    assign odd_trim = (cfg.clock_source_select == usart_baud_pkg::SRC_MCK)
                      && cfg.clock_divisor[0] && (cfg.clock_divisor != 16'h1);
    assign sck_out = odd_trim ? (sck_q || sck_late_q) : sck_q;

    // Receiver and transmitter enable control
    assign flush = cmd.transmitter_reset_cmd;
    assign f_pop = tx_en_q && !tx_busy_q && f_valid && !flush;
    always_comb begin
        rx_en_d = rx_en_q;
        rx_off_d = rx_off_q;
        tx_en_d = tx_en_q;
        tx_off_d = tx_off_q;
        tx_busy_d = tx_busy_q;
        tx_bits_d = tx_bits_q;
        word_d = word_q;
        start_d = 1'b0;
        if (cmd.receiver_enable_cmd) begin
            rx_en_d = 1'b1;
            rx_off_d = 1'b0;
        end
        if (cmd.receiver_disable_cmd && rx_en_q) begin
            rx_off_d = 1'b1;
        end
        if (rx_off_q && !rx_char_busy) begin
            rx_en_d = 1'b0;
            rx_off_d = 1'b0;
        end
        if (cmd.receiver_reset_cmd) begin
            rx_en_d = 1'b0;
            rx_off_d = 1'b0;
        end
        if (cmd.transmitter_enable_cmd) begin
            tx_en_d = 1'b1;
            tx_off_d = 1'b0;
        end
        if (cmd.transmitter_disable_cmd && tx_en_q) begin
            tx_off_d = 1'b1;
        end
        if (tx_busy_q && bit_tick) begin
            if (tx_bits_q == usart_baud_pkg::CHAR_BITS - 4'h1) begin
                tx_busy_d = 1'b0;
            end else begin
                tx_bits_d = tx_bits_q + 4'h1;
            end
        end
        if (f_pop) begin
            tx_busy_d = 1'b1;
            tx_bits_d = '0;
            word_d = f_data;
            start_d = 1'b1;
        end
        if (tx_off_q && !tx_busy_q && !f_valid) begin
            tx_en_d = 1'b0;
            tx_off_d = 1'b0;
        end
        if (cmd.transmitter_reset_cmd) begin
            tx_en_d = 1'b0;
            tx_off_d = 1'b0;
            tx_busy_d = 1'b0;
            start_d = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            pre_q <= '0;
            sck_prev_q <= 1'b0;
            div_q <= '0;
            acc_q <= '0;
            ext_q <= 1'b0;
            ovs_q <= '0;
            etu_q <= '0;
            ratio_q <= usart_baud_pkg::RATIO_RST;
            sck_q <= 1'b0;
            rx_en_q <= 1'b0;
            rx_off_q <= 1'b0;
            tx_en_q <= 1'b0;
            tx_off_q <= 1'b0;
            tx_busy_q <= 1'b0;
            tx_bits_q <= '0;
            word_q <= '0;
            start_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            sck_prev_q <= sck_in;
            div_q <= div_d;
            acc_q <= acc_d;
            ext_q <= ext_d;
            ovs_q <= ovs_d;
            etu_q <= etu_d;
            ratio_q <= ratio_d;
            sck_q <= sck_d;
            rx_en_q <= rx_en_d;
            rx_off_q <= rx_off_d;
            tx_en_q <= tx_en_d;
            tx_off_q <= tx_off_d;
            tx_busy_q <= tx_busy_d;
            tx_bits_q <= tx_bits_d;
            word_q <= word_d;
            start_q <= start_d;
        end
    end

    // Holding stage stalls the source while disabled or draining
    hold_fifo #(.WIDTH(usart_baud_pkg::WORD_W), .DEPTH(usart_baud_pkg::FIFO_DEPTH)) u_hold (
        .mclk(mclk),
        .reset(reset),
        .flush(flush),
        .in_valid(tx_valid && tx_en_q && !tx_off_q),
        .in_ready(tx_ready_in_raw),
        .in_data(tx_data),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );
    assign tx_ready_in = tx_ready_in_raw && tx_en_q && !tx_off_q;
    assign tx_start = start_q;
    assign tx_word = word_q;
    assign card_ratio = ratio_q;
    assign status = '{rx_enabled: rx_en_q, tx_enabled: tx_en_q,
                      tx_ready: tx_ready_in, tx_empty: tx_en_q && !tx_busy_q && !f_valid};

    property p_zero_div;
        @(posedge mclk) disable iff (reset)
        (cfg.clock_divisor == 16'h0 && !ext_sel) |-> !div_tick;
    endproperty
    a_zero_div: assert property (p_zero_div) else $error("tick with zero divisor");

    property p_bypass;
        @(posedge mclk) disable iff (reset)
        (cfg.clock_divisor == 16'h1 && !frac_on && cfg.clock_source_select == usart_baud_pkg::SRC_MCK)
        |-> div_tick;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass missed a tick");

    property p_ovs8;
        @(posedge mclk) disable iff (reset)
        (bit_tick && cfg.mode == usart_baud_pkg::OP_ASYNC && cfg.over8 && $stable(cfg))
        |-> ovs_q == usart_baud_pkg::OVS8_LAST;
    endproperty
    a_ovs8: assert property (p_ovs8) else $error("bit clock not eighth sample");

    property p_ovs16;
        @(posedge mclk) disable iff (reset)
        (bit_tick && cfg.mode == usart_baud_pkg::OP_ASYNC && !cfg.over8)
        |-> ovs_q == usart_baud_pkg::OVS16_LAST;
    endproperty
    a_ovs16: assert property (p_ovs16) else $error("bit clock not sixteenth sample");

    property p_ext_direct;
        @(posedge mclk) disable iff (reset)
        (cfg.mode == usart_baud_pkg::OP_SYNC && ext_sel && sck_in && !sck_prev_q) |-> bit_tick;
    endproperty
    a_ext_direct: assert property (p_ext_direct) else $error("pin clock not passed");

    property p_no_frac;
        @(posedge mclk) disable iff (reset)
        (div_tick && (!cfg.normal || cfg.mode != usart_baud_pkg::OP_ASYNC)) |=> !ext_q;
    endproperty
    a_no_frac: assert property (p_no_frac) else $error("fraction outside normal mode");

    property p_rx_drain;
        @(posedge mclk) disable iff (reset)
        (rx_off_q && rx_char_busy && !cmd.receiver_reset_cmd && !cmd.receiver_enable_cmd)
        |=> rx_en_q;
    endproperty
    a_rx_drain: assert property (p_rx_drain) else $error("receiver stopped mid character");

    property p_tx_drain;
        @(posedge mclk) disable iff (reset)
        (tx_en_q && !tx_en_d && !cmd.transmitter_reset_cmd) |-> !tx_busy_q && !f_valid;
    endproperty
    a_tx_drain: assert property (p_tx_drain) else $error("transmitter stopped with work");

    property p_reset_cmd;
        @(posedge mclk) disable iff (reset)
        (cmd.transmitter_reset_cmd && !ratio_wr)
        |=> !tx_en_q && !tx_busy_q && !f_valid && $stable(ratio_q);
    endproperty
    a_reset_cmd: assert property (p_reset_cmd) else $error("reset command incomplete");
endmodule // usart_baud_ctrl

/* usart_baud_pkg.sv */
/*
 Shared constants and carriers for the baud rate generator
 and the receiver/transmitter enable control.
 Assumes one 20 MHz master clock and a synchronous reset.
*/
package usart_baud_pkg;
    // Clock source select codes
    localparam logic [1:0] SRC_MCK = 2'h0;
    localparam logic [1:0] SRC_DIV = 2'h1;
    localparam logic [1:0] SRC_EXT = 2'h3;
    // Fixed prescaler of the divided source
    localparam logic [2:0] PRESC_LAST = 3'h7;
    // Oversampling counts, last index
    localparam logic [3:0] OVS16_LAST = 4'hf;
    localparam logic [3:0] OVS8_LAST = 4'h7;
    // Card ratio reset value, 372
    localparam logic [10:0] RATIO_RST = 11'h174;
    // Bit times per character in the transmit sequencer
    localparam logic [3:0] CHAR_BITS = 4'ha;
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W = 9;

    typedef enum logic [1:0] {
        OP_ASYNC,
        OP_SYNC,
        OP_SPI,
        OP_CARD
    } op_mode_e;

    typedef struct packed {
        op_mode_e mode;
        logic normal;
        logic over8;
        logic [1:0] clock_source_select;
        logic serial_clock_drive_out;
        logic [15:0] clock_divisor;
        logic [2:0] fractional_eighths;
    } baud_cfg_s;

    typedef struct packed {
        logic receiver_enable_cmd;
        logic receiver_disable_cmd;
        logic receiver_reset_cmd;
        logic transmitter_enable_cmd;
        logic transmitter_disable_cmd;
        logic transmitter_reset_cmd;
    } ctrl_cmd_s;

    typedef struct packed {
        logic rx_enabled;
        logic tx_enabled;
        logic tx_ready;
        logic tx_empty;
    } ctrl_status_s;
endpackage

/* serial_far_node.sv */
/*
 Far-side serial clock source for the baud generator bench.
 Assumes mclk is the bench clock and run changes off its edge.
*/
`timescale 1ns/1ps

module serial_far_node (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Frame control
    input wire logic run,
    // Serial clock pin
    output logic sck
);
    logic [2:0] cnt_q;

    // Ten mclk periods a clock; stands low outside frames
    always_ff @(posedge mclk) begin
        if (reset || !run) begin
            cnt_q <= 3'h0;
            sck <= 1'b0;
        end else if (cnt_q == 3'h4) begin
            cnt_q <= 3'h0;
            sck <= !sck;
        end else begin
            cnt_q <= cnt_q + 3'h1;
        end
    end
endmodule // serial_far_node

/* usart_baud_and_enable_control_tb.sv */
/*
 Self-checking bench for the baud generator and enable control.
 Assumes the far node drives the pin clock; all else from here.
*/
`timescale 1ns/1ps

module usart_baud_and_enable_control_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    usart_baud_pkg::baud_cfg_s cfg, c;
    usart_baud_pkg::ctrl_cmd_s cmd, k;
    usart_baud_pkg::ctrl_status_s status;
    logic ratio_wr, rx_char_busy, tx_valid, tx_ready_in, tx_start;
    logic [10:0] ratio_wdata, card_ratio;
    logic [8:0] tx_data, tx_word;
    logic sck_in, sck_out, sck_oe, sample_tick, bit_tick, etu_tick, run;
    int errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int starts = 0;
    int n, i;
    time t0, hi;

    always #25 mclk = !mclk;

    usart_baud_ctrl dut (.mclk(mclk), .reset(reset), .cfg(cfg), .cmd(cmd), .ratio_wr(ratio_wr),
        .ratio_wdata(ratio_wdata), .rx_char_busy(rx_char_busy), .tx_valid(tx_valid),
        .tx_ready_in(tx_ready_in), .tx_data(tx_data), .tx_start(tx_start), .tx_word(tx_word),
        .sck_in(sck_in), .sck_out(sck_out), .sck_oe(sck_oe), .sample_tick(sample_tick),
        .bit_tick(bit_tick), .etu_tick(etu_tick), .card_ratio(card_ratio), .status(status));

    serial_far_node far (.mclk(mclk), .reset(reset), .run(run), .sck(sck_in));

    task automatic chk(input string nm, input int e, input logic [15:0] g);
        cmp_count++;
        if (g !== 16'(e)) begin
            errors++;
            $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
        end
    endtask

    task automatic wrap_up();
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Hang guard, well beyond the whole sequence
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            wrap_up();
        end
    end

    // Word order out of the holding FIFO
    always @(negedge mclk) begin
        if (tx_start === 1'b1) begin
            chk("tx_word", 16'(starts), 16'(tx_word));
            starts++;
        end
    end

    function automatic logic tk(input int s);
        return s == 0 ? sample_tick : s == 1 ? bit_tick : etu_tick;
    endfunction

    // Short reset so counters restart cleanly on the new setting
    task automatic setcfg(input usart_baud_pkg::baud_cfg_s v);
        @(negedge mclk);
        cfg = v;
        reset = 1'b1;
        @(negedge mclk);
        reset = 1'b0;
    endtask

    task automatic nxt(input int s, output int m);
        m = 0;
        do begin
            @(negedge mclk);
            m++;
        end while (tk(s) !== 1'b1 && m < 3000);
    endtask

    task automatic gap(input int s, input int e, input string nm);
        int m;
        nxt(s, m);
        nxt(s, m);
        chk(nm, 16'(e), 16'(m));
    endtask

    task automatic cnt(input int s, input int len, output int m);
        m = 0;
        repeat (len) begin
            @(negedge mclk);
            if (tk(s) === 1'b1) m++;
        end
    endtask

    task automatic pulse(input usart_baud_pkg::ctrl_cmd_s v);
        @(negedge mclk);
        cmd = v;
        @(negedge mclk);
        cmd = '0;
        repeat (2) @(negedge mclk);
    endtask

    task automatic wr_ratio(input logic [10:0] v);
        @(negedge mclk);
        ratio_wr = 1'b1;
        ratio_wdata = v;
        @(negedge mclk);
        ratio_wr = 1'b0;
    endtask

    task automatic t_reset();
        chk("rx_en", 0, 16'(status.rx_enabled));
        chk("tx_en", 0, 16'(status.tx_enabled));
        chk("tx_rdy", 0, 16'(status.tx_ready));
        chk("ratio", 16'h174, 16'(card_ratio));
    endtask

    task automatic t_async();
        c = '0;
        c.mode = usart_baud_pkg::OP_ASYNC;
        c.normal = 1'b1;
        c.clock_divisor = 16'h3;
        setcfg(c);
        gap(1, 48, "bit16");
        c.over8 = 1'b1;
        setcfg(c);
        gap(1, 24, "bit8");
        gap(0, 3, "sample");
        c.clock_divisor = 16'h1;
        setcfg(c);
        gap(1, 8, "bypass");
        c.clock_source_select = usart_baud_pkg::SRC_DIV;
        setcfg(c);
        gap(1, 64, "presc");
        c.clock_source_select = usart_baud_pkg::SRC_MCK;
        c.clock_divisor = 16'h2;
        c.fractional_eighths = 3'h4;
        setcfg(c);
        gap(1, 20, "frac");
        c.fractional_eighths = 3'h7;
        setcfg(c);
        gap(1, 23, "frac7");
        c.normal = 1'b0;
        setcfg(c);
        gap(1, 16, "nofrac");
    endtask

    task automatic t_sync();
        c = '0;
        c.mode = usart_baud_pkg::OP_SYNC;
        c.normal = 1'b1;
        c.serial_clock_drive_out = 1'b1;
        c.clock_divisor = 16'h5;
        c.fractional_eighths = 3'h4;
        setcfg(c);
        gap(1, 5, "sync");
        chk("oe_int", 1, 16'(sck_oe));
        c.mode = usart_baud_pkg::OP_SPI;
        setcfg(c);
        gap(1, 5, "spi");
        c.clock_divisor = 16'h4;
        setcfg(c);
        n = 0;
        while (sck_out !== 1'b0 && n < 50) begin @(negedge mclk); n++; end
        while (sck_out !== 1'b1 && n < 50) begin @(negedge mclk); n++; end
        n = 0;
        while (sck_out === 1'b1 && n < 50) begin @(negedge mclk); n++; end
        chk("sck_high", 2, 16'(n));
        c.clock_divisor = 16'h5;
        setcfg(c);
        @(posedge sck_out);
        t0 = $time;
        @(negedge sck_out);
        hi = $time - t0;
        @(posedge sck_out);
        chk("sck_hi_odd", 125, 16'(hi));
        chk("sck_lo_odd", 125, 16'($time - t0 - hi));
        c.clock_divisor = 16'h0;
        setcfg(c);
        cnt(1, 200, n);
        chk("cd0", 0, 16'(n));
        c.mode = usart_baud_pkg::OP_SYNC;
        c.clock_divisor = 16'h7;
        c.clock_source_select = usart_baud_pkg::SRC_EXT;
        setcfg(c);
        chk("oe_ext", 0, 16'(sck_oe));
        run = 1'b1;
        cnt(1, 200, i);
        run = 1'b0;
        cnt(1, 20, n);
        chk("ext", 20, 16'(i + n));
    endtask

    task automatic t_card();
        c = '0;
        c.mode = usart_baud_pkg::OP_CARD;
        c.serial_clock_drive_out = 1'b1;
        c.clock_divisor = 16'h2;
        setcfg(c);
        wr_ratio(11'h5);
        chk("ratio_wr", 5, 16'(card_ratio));
        gap(2, 10, "etu");
        chk("oe_card", 1, 16'(sck_oe));
    endtask

    task automatic t_enable();
        c = '0;
        c.over8 = 1'b1;
        c.clock_divisor = 16'h1;
        setcfg(c);
        wr_ratio(11'h9);
        k = '0;
        k.receiver_enable_cmd = 1'b1;
        k.transmitter_enable_cmd = 1'b1;
        pulse(k);
        chk("both_rx", 1, 16'(status.rx_enabled));
        chk("both_tx", 1, 16'(status.tx_enabled));
        chk("both_rdy", 1, 16'(status.tx_ready));
        chk("both_empty", 1, 16'(status.tx_empty));
        k = '0;
        k.receiver_reset_cmd = 1'b1;
        pulse(k);
        chk("rst_rx", 0, 16'(status.rx_enabled));
        chk("rst_tx", 1, 16'(status.tx_enabled));
        chk("keep", 9, 16'(card_ratio));
        k = '0;
        k.receiver_enable_cmd = 1'b1;
        pulse(k);
        chk("rx_alone", 1, 16'(status.rx_enabled));
        rx_char_busy = 1'b1;
        k = '0;
        k.receiver_disable_cmd = 1'b1;
        pulse(k);
        repeat (20) @(negedge mclk);
        chk("rx_wait", 1, 16'(status.rx_enabled));
        rx_char_busy = 1'b0;
        repeat (3) @(negedge mclk);
        chk("rx_off", 0, 16'(status.rx_enabled));
    endtask

    task automatic t_drain();
        tx_valid = 1'b1;
        tx_data = 9'h0;
        n = 0;
        for (i = 0; i < 20; i++) begin
            if (tx_ready_in === 1'b1) n++;
            @(negedge mclk);
            tx_data = 9'(n);
        end
        tx_valid = 1'b0;
        chk("full", 1, 16'(n >= 8));
        k = '0;
        k.transmitter_disable_cmd = 1'b1;
        pulse(k);
        chk("tx_hold", 1, 16'(status.tx_enabled));
        chk("refuse", 0, 16'(tx_ready_in));
        i = 0;
        while (status.tx_enabled !== 1'b0 && i < 1500) begin @(negedge mclk); i++; end
        chk("sent", 16'(n), 16'(starts));
        chk("tx_off", 0, 16'(status.tx_enabled));
        chk("tx_empty_off", 0, 16'(status.tx_empty));
        k = '0;
        k.transmitter_enable_cmd = 1'b1;
        pulse(k);
        k = '0;
        k.transmitter_reset_cmd = 1'b1;
        pulse(k);
        chk("rst_tx", 0, 16'(status.tx_enabled));
    endtask

    initial begin
        cfg = '0;
        cfg.clock_divisor = 16'h1;
        cmd = '0;
        ratio_wr = 1'b0;
        ratio_wdata = 11'h0;
        rx_char_busy = 1'b0;
        tx_valid = 1'b0;
        tx_data = 9'h0;
        run = 1'b0;
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        t_reset();
        t_async();
        t_sync();
        t_card();
        t_enable();
        t_drain();
        wrap_up();
    end
endmodule // usart_baud_and_enable_control_tb
